// ===== hdl/vfc_pkg.sv
// package for the vector fp compare and classify unit
package vfc_pkg;
   localparam int VFC_VLEN = 128;
   localparam int VFC_W32 = 32;
   localparam int VFC_W64 = 64;
   localparam int VFC_N32 = VFC_VLEN / VFC_W32;
   localparam int VFC_N64 = VFC_VLEN / VFC_W64;
   localparam int VFC_CLS_W = 10;
   // class mask bit positions
   localparam int VFC_CLS_SNAN = 0;
   localparam int VFC_CLS_QNAN = 1;
   localparam int VFC_CLS_NINF = 2;
   localparam int VFC_CLS_NNORM = 3;
   localparam int VFC_CLS_NSUB = 4;
   localparam int VFC_CLS_NZERO = 5;
   localparam int VFC_CLS_PINF = 6;
   localparam int VFC_CLS_PNORM = 7;
   localparam int VFC_CLS_PSUB = 8;
   localparam int VFC_CLS_PZERO = 9;
   // exception flags reset value
   localparam logic [2:0] VFC_EXC_RST = 3'h0;

   typedef enum logic [2:0] {
      VFC_OP_EQ,
      VFC_OP_LE,
      VFC_OP_LT,
      VFC_OP_NE,
      VFC_OP_OR,
      VFC_OP_CLASS
   } vfc_op_t;

   typedef struct packed {
      logic valid;
      vfc_op_t op;
      logic fmt64;
      logic flush_to_zero_bit;
      logic unit_enable;
      logic [VFC_VLEN-1:0] first_source_vector;
      logic [VFC_VLEN-1:0] second_source_vector;
   } vfc_req_t;

   typedef struct packed {
      logic reserved_instr;
      logic unit_disabled;
      logic fp_exception;
   } vfc_exc_t;
endpackage

// ===== hdl/vfc_unit.sv
// vector fp quiet compare and classify datapath, one-cycle latency
// ==============================================================
// Overview of operation
// - equal compare gives all ones when ordered and equal, else zeros.
// - less-or-equal gives all ones when ordered and a <= b.
// - less-than gives all ones when ordered and a strictly below b.
// - not-equal gives all ones only when ordered and unequal.
// - ordered compare sets all bits when ordered, clears otherwise.
// - a pair is ordered only when neither element is NaN.
// - on a floating-point exception the element result is all zeros.
// - flushing subnormal inputs never raises inexact.
// - compares are quiet and follow the IEEE 754-2008 rules.
// - a signaling NaN in either compare source raises invalid.
// - compares may raise reserved, unit disabled or fp exceptions.
// - word form uses 32-bit elements, doubleword 64-bit elements.
// - operands are fp of the format, results integers same width.
// - classify stores a 10-bit mask; bit0 signaling, bit1 quiet NaN.
// - negative: bit2 inf, bit3 normal, bit4 subnormal, bit5 zero.
// - positive: bit6 inf, bit7 normal, bit8 subnormal, bit9 zero.
// - classify ignores flush-to-zero, subnormals stay subnormal.
// - classify raises only reserved or unit disabled exceptions.
`timescale 1ns/10ps
module vfc_unit
   import vfc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire vfc_req_t i_req,
   output logic o_valid,
   output logic [VFC_VLEN-1:0] o_dest_vector,
   output vfc_exc_t o_exc,
   output logic o_invalid_flag
);

   // ==============================================================
   // element helpers
   // per-element decode; ftz applied only for compares
   typedef struct packed {
      logic nan;
      logic snan;
      logic qnan;
      logic inf;
      logic zero;
      logic sub;
      logic neg;
   } vfc_cls_t;

   function automatic vfc_cls_t cls32(input logic [31:0] v);
      vfc_cls_t c;
      c.neg = v[31];
      c.inf = (v[30:23] == 8'hff) && (v[22:0] == 23'h0);
      c.nan = (v[30:23] == 8'hff) && (v[22:0] != 23'h0);
      c.qnan = c.nan && v[22];
      c.snan = c.nan && !v[22];
      c.zero = (v[30:0] == 31'h0);
      c.sub = (v[30:23] == 8'h00) && (v[22:0] != 23'h0);
      return c;
   endfunction

   function automatic vfc_cls_t cls64(input logic [63:0] v);
      vfc_cls_t c;
      c.neg = v[63];
      c.inf = (v[62:52] == 11'h7ff) && (v[51:0] == 52'h0);
      c.nan = (v[62:52] == 11'h7ff) && (v[51:0] != 52'h0);
      c.qnan = c.nan && v[51];
      c.snan = c.nan && !v[51];
      c.zero = (v[62:0] == 63'h0);
      c.sub = (v[62:52] == 11'h000) && (v[51:0] != 52'h0);
      return c;
   endfunction

   // class mask from decode, never flushed
   function automatic logic [VFC_CLS_W-1:0] mask_of(input vfc_cls_t c);
      logic [VFC_CLS_W-1:0] m;
      logic norm;
      m = '0;
      norm = !c.nan && !c.inf && !c.zero && !c.sub;
      m[VFC_CLS_SNAN] = c.snan;
      m[VFC_CLS_QNAN] = c.qnan;
      m[VFC_CLS_NINF] = c.neg && c.inf;
      m[VFC_CLS_NNORM] = c.neg && norm;
      m[VFC_CLS_NSUB] = c.neg && c.sub;
      m[VFC_CLS_NZERO] = c.neg && c.zero;
      m[VFC_CLS_PINF] = !c.neg && c.inf;
      m[VFC_CLS_PNORM] = !c.neg && norm;
      m[VFC_CLS_PSUB] = !c.neg && c.sub;
      m[VFC_CLS_PZERO] = !c.neg && c.zero;
      return m;
   endfunction

   // quiet compare on sign-magnitude values; zero handles +0 == -0
   function automatic logic cmp_bit(input vfc_op_t op,
                                    input logic a_neg,
                                    input logic b_neg,
                                    input logic [62:0] a_mag,
                                    input logic [62:0] b_mag,
                                    input logic a_zero,
                                    input logic b_zero,
                                    input logic unord);
      logic eq;
      logic lt;
      eq = (a_zero && b_zero) || (a_neg == b_neg && a_mag == b_mag);
      if (a_zero && b_zero) begin
         lt = 1'b0;
      end else if (a_neg != b_neg) begin
         lt = a_neg;
      end else if (a_neg) begin
         lt = a_mag > b_mag;
      end else begin
         lt = a_mag < b_mag;
      end
      // unordered pairs always answer false
      unique case (op)
         VFC_OP_EQ: cmp_bit = !unord && eq;
         VFC_OP_LE: cmp_bit = !unord && (lt || eq);
         VFC_OP_LT: cmp_bit = !unord && lt;
         VFC_OP_NE: cmp_bit = !unord && !eq;
         VFC_OP_OR: cmp_bit = !unord;
         VFC_OP_CLASS: cmp_bit = 1'b0;
         default: cmp_bit = 1'b0; // codes 6 and 7 are refused upstream
      endcase
   endfunction

   // ==============================================================
   // per-lane datapath
   logic [VFC_VLEN-1:0] res32;
   logic [VFC_VLEN-1:0] res64;
   logic [VFC_N32-1:0] snan32;
   logic [VFC_N64-1:0] snan64;
   logic is_class;
   assign is_class = (i_req.op == VFC_OP_CLASS);

   genvar gi;
   generate
      for (gi = 0; gi < VFC_N32; gi++) begin : g_w
         logic [31:0] a;
         logic [31:0] b;
         vfc_cls_t ca;
         vfc_cls_t cb;
         logic az;
         logic bz;
         logic bit_r;
         assign a = i_req.first_source_vector[gi*32 +: 32];
         assign b = i_req.second_source_vector[gi*32 +: 32];
         assign ca = cls32(a);
         assign cb = cls32(b);
         // flushed subnormals compare as zero; no inexact is produced
         assign az = ca.zero || (i_req.flush_to_zero_bit && ca.sub);
         assign bz = cb.zero || (i_req.flush_to_zero_bit && cb.sub);
         assign bit_r = cmp_bit(i_req.op, a[31], b[31], {32'h0, a[30:0]},
                                {32'h0, b[30:0]}, az, bz,
                                ca.nan || cb.nan);
         assign snan32[gi] = ca.snan || cb.snan;
         // snan forces zero result, which the compare already yields
         assign res32[gi*32 +: 32] = is_class ?
            {22'h0, mask_of(ca)} :
            {32{bit_r && !snan32[gi]}};
      end
      for (gi = 0; gi < VFC_N64; gi++) begin : g_d
         logic [63:0] a;
         logic [63:0] b;
         vfc_cls_t ca;
         vfc_cls_t cb;
         logic az;
         logic bz;
         logic bit_r;
         assign a = i_req.first_source_vector[gi*64 +: 64];
         assign b = i_req.second_source_vector[gi*64 +: 64];
         assign ca = cls64(a);
         assign cb = cls64(b);
         assign az = ca.zero || (i_req.flush_to_zero_bit && ca.sub);
         assign bz = cb.zero || (i_req.flush_to_zero_bit && cb.sub);
         assign bit_r = cmp_bit(i_req.op, a[63], b[63], a[62:0], b[62:0],
                                az, bz, ca.nan || cb.nan);
         assign snan64[gi] = ca.snan || cb.snan;
         assign res64[gi*64 +: 64] = is_class ?
            {54'h0, mask_of(ca)} :
            {64{bit_r && !snan64[gi]}};
      end
   endgenerate

   // ==============================================================
   // exception decode
   logic op_legal;
   logic any_snan;
   vfc_exc_t exc_next;
   assign op_legal = (i_req.op inside {VFC_OP_EQ, VFC_OP_LE, VFC_OP_LT,
                                       VFC_OP_NE, VFC_OP_OR,
                                       VFC_OP_CLASS});
   assign any_snan = i_req.fmt64 ? |snan64 : |snan32;
   // classify never flags fp; disabled unit outranks data faults
   always_comb begin
      exc_next.reserved_instr = !op_legal;
      exc_next.unit_disabled = op_legal && !i_req.unit_enable;
      exc_next.fp_exception = op_legal && i_req.unit_enable &&
                              !is_class && any_snan;
   end

   // ==============================================================
   // result register
   logic [VFC_VLEN-1:0] dest_next;
   assign dest_next = i_req.fmt64 ? res64 : res32;

   // valid strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_req.valid;
      end
   end

   // destination vector; reserved or disabled issue writes zeros
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dest_vector <= '0;
      end else if (i_req.valid) begin
         if (exc_next.reserved_instr || exc_next.unit_disabled) begin
            o_dest_vector <= '0;
         end else begin
            o_dest_vector <= dest_next;
         end
      end
   end

   // exception outputs, valid alongside o_valid
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_exc <= VFC_EXC_RST;
         o_invalid_flag <= 1'b0;
      end else if (i_req.valid) begin
         o_exc <= exc_next;
         o_invalid_flag <= exc_next.fp_exception;
      end else begin
         o_exc <= VFC_EXC_RST;
         o_invalid_flag <= 1'b0;
      end
   end

   // ==============================================================
   // checks
   // request shapes, sampled on the taking edge; answers one edge on
   sequence issue_class_s;
      i_req.valid && is_class;
   endsequence

   sequence issue_class_ok_s;
      i_req.valid && is_class && i_req.unit_enable;
   endsequence

   // accepted compares, split by element width
   sequence issue_cmp32_s;
      i_req.valid && op_legal && !is_class && i_req.unit_enable &&
      !i_req.fmt64;
   endsequence

   sequence issue_cmp64_s;
      i_req.valid && op_legal && !is_class && i_req.unit_enable &&
      i_req.fmt64;
   endsequence

   // refused issue: illegal code or unit switched off
   sequence issue_refused_s;
      i_req.valid && (!op_legal || !i_req.unit_enable);
   endsequence

   class_no_fp_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      issue_class_s |=> !o_exc.fp_exception)
      else $error("classify raised fp exception");

   snan_invalid_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ((issue_cmp32_s or issue_cmp64_s) ##0 any_snan) |=> o_invalid_flag)
      else $error("signaling nan missed invalid");

   fp_exc_zero_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ((issue_cmp32_s ##0 snan32[0]) or (issue_cmp64_s ##0 snan64[0]))
      |=> o_dest_vector[31:0] == 32'h0 && o_exc.fp_exception)
      else $error("fp exception result not zero");

   valid_lat_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      i_req.valid |=> o_valid)
      else $error("result valid missing");

   valid_pulse_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !i_req.valid |=> !o_valid && !o_invalid_flag &&
      o_exc == VFC_EXC_RST)
      else $error("result strobe outside an issue");

   class_upper_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_class_s ##1 o_valid) |-> o_dest_vector[31:VFC_CLS_W] == '0)
      else $error("class upper bits not zero");

   class_onehot_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      issue_class_ok_s |=> $onehot(o_dest_vector[VFC_CLS_W-1:0]))
      else $error("class mask not exactly one bit");

   class_sub_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_class_ok_s ##0 (!i_req.fmt64 && g_w[0].ca.sub &&
       !g_w[0].a[31])) |=> o_dest_vector[VFC_CLS_PSUB])
      else $error("subnormal not classed subnormal");

   ord_nan_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp32_s ##0 (i_req.op == VFC_OP_OR && g_w[3].ca.nan)) |=>
      o_dest_vector[127:96] == 32'h0)
      else $error("ordered true with nan");

   cmp_nan_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp32_s ##0 (g_w[3].ca.nan || g_w[3].cb.nan)) |=>
      o_dest_vector[127:96] == 32'h0)
      else $error("compare true with nan");

   ne_nan_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp64_s ##0 (i_req.op == VFC_OP_NE && g_d[0].cb.nan)) |=>
      o_dest_vector[63:0] == 64'h0)
      else $error("not equal true with nan");

   eq_self_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp32_s ##0 (i_req.op == VFC_OP_EQ && !g_w[0].ca.nan &&
       g_w[0].a == g_w[0].b)) |=> o_dest_vector[31:0] == 32'hffff_ffff)
      else $error("equal failed on identical values");

   le_self_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp32_s ##0 (i_req.op == VFC_OP_LE && !g_w[0].ca.nan &&
       g_w[0].a == g_w[0].b)) |=> o_dest_vector[31:0] == 32'hffff_ffff)
      else $error("less or equal failed on identical values");

   ftz_no_flag_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (issue_cmp32_s ##0 (i_req.flush_to_zero_bit && !any_snan)) |=>
      !o_exc.fp_exception)
      else $error("flushing raised an exception");

   refuse_zero_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      issue_refused_s |=> o_dest_vector == '0 && !o_exc.fp_exception &&
      !o_invalid_flag)
      else $error("refused issue left a result");

   reserved_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_req.valid && !op_legal) |=> o_exc.reserved_instr &&
      !o_exc.unit_disabled)
      else $error("illegal code not reported as reserved");
endmodule

// ===== tb/vfc_host_model.sv
// host pipeline model that issues requests to the compare unit
`timescale 1ns/10ps
module vfc_host_model
   import vfc_pkg::*;
(
   input wire logic i_clk,
   output vfc_req_t o_req
);
   // ==========================================================
   // request issue
   // idle request at time zero, nothing valid before reset ends
   initial begin
      o_req = '0;
   end

   // one request per call, held for exactly one taking edge;
   // operands inverted once released so stale data cannot pass
   task automatic issue(input logic [2:0] op, input logic fmt64,
         input logic ftz, input logic en, input logic [127:0] a,
         input logic [127:0] b);
      @(posedge i_clk);
      o_req <= '{1'b1, vfc_op_t'(op), fmt64, ftz, en, a, b};
      @(posedge i_clk);
      o_req <= '{1'b0, vfc_op_t'(op), fmt64, ftz, en, ~a, ~b};
   endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the vector compare and classify unit
`timescale 1ns/10ps
module tb
   import vfc_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   vfc_req_t req;
   logic o_valid;
   logic [VFC_VLEN-1:0] dest;
   vfc_exc_t exc;
   logic inv;
   int n_fail = 0;
   int samples_checked = 0;

   // ==========================================================
   // clock, reset and instances
   // 50 ns period for the 20 MHz core clock
   always #25 i_clk = ~i_clk;

   vfc_host_model host (.i_clk(i_clk), .o_req(req));
   vfc_unit DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
      .o_valid(o_valid), .o_dest_vector(dest), .o_exc(exc),
      .o_invalid_flag(inv));

   // ==========================================================
   // checking helpers
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // each set mask bit becomes one all-ones word element
   function automatic logic [127:0] spread(input logic [3:0] m);
      logic [127:0] r;
      for (int i = 0; i < 4; i++) begin
         r[32*i+:32] = {32{m[i]}};
      end
      return r;
   endfunction

   // issue one request, judge the answer one edge later
   task automatic run(input logic [2:0] op, input logic f64,
         input logic ftz, input logic en, input logic [127:0] a,
         input logic [127:0] b, input logic [127:0] ed,
         input logic [2:0] ee, input logic ei);
      host.issue(op, f64, ftz, en, a, b);
      @(negedge i_clk);
      chk(o_valid, 1'b1);
      chk(dest, ed);
      chk(exc, ee);
      chk(inv, ei);
   endtask

   // ==========================================================
   // scenarios
   // pairs: (1,1) (1,2) (2,1) (qnan,1); quiet nan raises nothing
   task automatic t_cmp32();
      logic [3:0] m [5];
      logic [127:0] a;
      logic [127:0] b;
      m = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h7};
      a = {32'h7FC0_0000, 32'h4000_0000, 32'h3F80_0000, 32'h3F80_0000};
      b = {32'h3F80_0000, 32'h3F80_0000, 32'h4000_0000, 32'h3F80_0000};
      for (int k = 0; k < 5; k++) begin
         run(3'(k), 1'b0, 1'b0, 1'b1, a, b, spread(m[k]), 3'h0, 1'b0);
      end
   endtask

   // signaling nan zeroes its element, signed zeros still equal
   task automatic t_snan64();
      logic [127:0] a;
      logic [127:0] b;
      a = {64'h8000_0000_0000_0000, 64'h7FF0_0000_0000_0001};
      b = {64'h0000_0000_0000_0000, 64'h3FF0_0000_0000_0000};
      run(3'h0, 1'b1, 1'b0, 1'b1, a, b, {{64{1'b1}}, 64'h0}, 3'h1, 1'b1);
      // quiet nan against one: not equal stays false, no flag raised
      run(3'h3, 1'b1, 1'b0, 1'b1, {2{64'h3FF0_0000_0000_0000}},
         {64'h4000_0000_0000_0000, 64'h7FF8_0000_0000_0000},
         {{64{1'b1}}, 64'h0}, 3'h0, 1'b0);
   endtask

   // subnormal equals zero only while flushing, with no flag
   task automatic t_flush();
      run(3'h0, 1'b0, 1'b1, 1'b1, 128'h1, 128'h0, {128{1'b1}}, 3'h0, 1'b0);
      run(3'h0, 1'b0, 1'b0, 1'b1, 128'h1, 128'h0, spread(4'hE), 3'h0, 1'b0);
   endtask

   // every class bit once; flushing must not turn subnormal to zero
   task automatic t_class();
      run(3'h5, 1'b0, 1'b0, 1'b1, {32'hBF80_0000, 32'hFF80_0000,
         32'h7FC0_0000, 32'h7F80_0001}, 128'h0, {32'h8, 32'h4, 32'h2,
         32'h1}, 3'h0, 1'b0);
      run(3'h5, 1'b0, 1'b0, 1'b1, {32'h3F80_0000, 32'h7F80_0000,
         32'h8000_0000, 32'h8000_0001}, 128'h0, {32'h80, 32'h40,
         32'h20, 32'h10}, 3'h0, 1'b0);
      run(3'h5, 1'b0, 1'b1, 1'b1, {64'h0, 64'h1}, 128'h0, {32'h200,
         32'h200, 32'h200, 32'h100}, 3'h0, 1'b0);
      run(3'h5, 1'b1, 1'b1, 1'b1, {64'hFFF0_0000_0000_0000, 64'h1},
         128'h0, {64'h4, 64'h100}, 3'h0, 1'b0);
   endtask

   // illegal op code and disabled unit are refused with zero result
   task automatic t_refuse();
      run(3'h6, 1'b0, 1'b0, 1'b1, 128'h1, 128'h1, 128'h0, 3'h4, 1'b0);
      run(3'h0, 1'b0, 1'b0, 1'b0, 128'h1, 128'h1, 128'h0, 3'h2, 1'b0);
   endtask

   // ==========================================================
   // verdict and main sequence
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // run takes about forty-two cycles; watchdog allows far more
   initial begin
      repeat (2000) @(posedge i_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      chk(o_valid, 1'b0);
      t_cmp32();
      t_snan64();
      t_flush();
      t_class();
      t_refuse();
      finish_test();
   end
endmodule
